/* File: lfs_regs.sv */
// Notes on behaviour
// RULE1: power-loss flag bit4 set by every reset
// RULE2: ch2 undervolt bit3 latched, read clears if gone
// RULE3: ch1 undervolt bit2 latched, read clears if gone
// RULE4: boot undervolt turns off high side, sets flag
// RULE5: overtemp bit1 latched, read clears if gone
// RULE6: sample above limit sets warning; limit resets 80h
// RULE7: link fault bit0 latched, cleared by status read
// RULE8: bad count, nonzero read data, parity set fault
// RULE9: every response frame carries link fault bit; a write as first command after reset gets 8000h, msb set with no link fault
// RULE10: read responses carry the four status flags
// RULE11: host reads power-loss flag at start-up
// RULE12: host picks limit code by temperature formula
// RULE13: peak code writable anytime, forwarded to converter
// RULE14: peak code means threshold in millivolts
// RULE15: recorded fault sets msb of next response
// RULE16: read response order fault,11,flags,nine data
// RULE17: status read returns flags from before clearing
// RULE18: reserved bits read zero, writes ignored
module lfs_regs
  import lfs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [4:0] cmd_addr,
  input wire logic [lfs_pkg::LFS_DATA_W-1:0] cmd_data,
  input wire logic cmd_parity_err,
  input wire logic frame_count_err,
  input wire logic ch1_boot_uv,
  input wire logic ch2_boot_uv,
  input wire logic [7:0] temp_adc_sample,
  output logic resp_valid,
  output logic [lfs_pkg::LFS_FRAME_W-1:0] resp_frame,
  output logic [lfs_pkg::LFS_NFLAGS-1:0] status_flags,
  output logic [7:0] temp_limit_code,
  output logic [7:0] ch1_peak_current_code,
  output logic ch1_dac_load,
  output logic ch1_hs_off,
  output logic ch2_hs_off
);

  lfs_state_t s_r;
  lfs_state_t s_nxt;
  logic [LFS_NFLAGS-1:0] flags;
  logic [LFS_NFLAGS-1:0] set_vec;
  logic [LFS_NFLAGS-1:0] hold_vec;
  logic cmd_err;
  logic status_rd;
  logic spe_now;

  // ****************************************
  // command decode and flag sources
  // ****************************************
  assign cmd_err = cmd_valid && (cmd_parity_err || (!cmd_write && (cmd_data != '0))); // [RULE8]
  assign status_rd = cmd_valid && !cmd_write && (cmd_addr == LFS_ADDR_STATUS);
  assign spe_now = flags[LFS_BIT_LINK] || cmd_err || frame_count_err; // [RULE9] [RULE15]
  assign set_vec = {1'h0, 1'h0, 1'h0, s_r.over_temp, cmd_err || frame_count_err}; // [RULE8]
  assign hold_vec = {1'h0, s_r.hs_off[1], s_r.hs_off[0], s_r.over_temp, 1'h0}; // [RULE2] [RULE3] [RULE5]

  // ****************************************
  // one sticky cell per status flag
  // ****************************************
  for (genvar i = 0; i < LFS_NFLAGS; i++) begin : g_flag
    lfs_flag_cell #(
      .RST_VAL(LFS_FLAGS_RST[i]) // [RULE1]
    ) u_cell (
      .mclk(mclk),
      .rst(rst),
      .set_evt(set_vec[i]),
      .cond_now(hold_vec[i]),
      .clr_req(status_rd), // [RULE7] [RULE17]
      .flag(flags[i])
    );
  end

  // ****************************************
  // registers, conditions and response frame
  // ****************************************
  always_comb begin
    logic [LFS_DATA_W-1:0] rdata;
    rdata = '0;
    s_nxt = s_r;
    s_nxt.dac_load = 1'h0;
    s_nxt.resp_valid = 1'h0;
    s_nxt.hs_off = {ch2_boot_uv, ch1_boot_uv}; // [RULE4]
    s_nxt.over_temp = (temp_adc_sample > s_r.limit); // [RULE6]
    case (cmd_addr)
      LFS_ADDR_STATUS: rdata = {4'h0, flags}; // [RULE17] [RULE18]
      LFS_ADDR_LIMIT: rdata = {1'h0, s_r.limit}; // [RULE18]
      LFS_ADDR_PEAK: rdata = {1'h0, s_r.peak}; // [RULE18]
      default: rdata = '0;
    endcase
    if (cmd_valid) begin
      s_nxt.resp_valid = 1'h1;
      s_nxt.phase = LFS_PH_RUN;
      if (!cmd_write) begin
        // read answer even when the command was faulty
        s_nxt.resp = {spe_now, LFS_RSVD_ONES, flags[LFS_BIT_PC], flags[LFS_BIT_UV2],
                      flags[LFS_BIT_UV1], flags[LFS_BIT_THERM], rdata}; // [RULE10] [RULE16]
      end else if (cmd_err || frame_count_err || s_r.phase == LFS_PH_POR) begin
        s_nxt.resp = LFS_ERR_FRAME; // [RULE15]
      end else begin
        s_nxt.resp = {spe_now, cmd_write, cmd_addr, cmd_data}; // [RULE9]
      end
      // bad writes are discarded, bit 8 ignored
      if (cmd_write && !cmd_err && !frame_count_err) begin
        if (cmd_addr == LFS_ADDR_LIMIT) begin
          s_nxt.limit = cmd_data[7:0]; // [RULE18]
        end
        if (cmd_addr == LFS_ADDR_PEAK) begin
          s_nxt.peak = cmd_data[7:0]; // [RULE13] [RULE14]
          s_nxt.dac_load = 1'h1;
        end
      end
    end
  end

  // register the state
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r.phase <= LFS_PH_POR;
      s_r.limit <= LFS_LIMIT_RST; // [RULE6]
      s_r.peak <= LFS_PEAK_RST; // [RULE13]
      s_r.dac_load <= 1'h0;
      s_r.hs_off <= 2'h0;
      s_r.over_temp <= 1'h0;
      s_r.resp_valid <= 1'h0;
      s_r.resp <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flip-flops
  assign resp_valid = s_r.resp_valid;
  assign resp_frame = s_r.resp;
  assign status_flags = flags;
  assign temp_limit_code = s_r.limit;
  assign ch1_peak_current_code = s_r.peak;
  assign ch1_dac_load = s_r.dac_load;
  assign ch1_hs_off = s_r.hs_off[0];
  assign ch2_hs_off = s_r.hs_off[1];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_power_loss_set: assert property ($fell(rst) |-> flags[LFS_BIT_PC]) // [RULE1]
    else $error("power-loss flag not set after reset");
  a_uv2_held: assert property (ch2_boot_uv ##1 status_rd |=> flags[LFS_BIT_UV2]) // [RULE2]
    else $error("ch2 undervolt flag cleared while present");
  a_uv1_held: assert property (ch1_boot_uv ##1 status_rd |=> flags[LFS_BIT_UV1]) // [RULE3]
    else $error("ch1 undervolt flag cleared while present");
  a_hs_off_uv: assert property (ch1_boot_uv |=> ch1_hs_off ##1 flags[LFS_BIT_UV1]) // [RULE4]
    else $error("high side not turned off on undervolt");
  a_therm_set: assert property (temp_adc_sample > temp_limit_code // [RULE5] [RULE6]
      |=> ##1 flags[LFS_BIT_THERM])
    else $error("thermal warning not set");
  a_link_clear: assert property (status_rd && !cmd_err && !frame_count_err // [RULE7]
      |=> !flags[LFS_BIT_LINK])
    else $error("link fault not cleared by status read");
  a_link_set: assert property (cmd_err // [RULE8] [RULE15]
      |=> flags[LFS_BIT_LINK] && resp_valid && resp_frame[15])
    else $error("link fault not set or not reported");
  a_read_order: assert property (cmd_valid && !cmd_write |=> // [RULE10] [RULE16]
      resp_frame[14:13] == LFS_RSVD_ONES && resp_frame[12:9] == $past(flags[4:1]))
    else $error("read response layout wrong");
  a_status_pre: assert property (status_rd |=> resp_frame[4:0] == $past(flags)) // [RULE17]
    else $error("status read did not return pre-clear flags");
  a_peak_write: assert property (cmd_valid && cmd_write && cmd_addr == LFS_ADDR_PEAK // [RULE13]
      && !cmd_err && !frame_count_err
      |=> ch1_dac_load && ch1_peak_current_code == $past(cmd_data[7:0]))
    else $error("peak code write not forwarded");
  a_bad_write: assert property (cmd_valid && cmd_write && cmd_err |=> // [RULE8] [RULE9]
      resp_frame == LFS_ERR_FRAME
      && $stable(temp_limit_code) && $stable(ch1_peak_current_code))
    else $error("faulty write not discarded");
  a_rsvd_zero: assert property (cmd_valid && !cmd_write && cmd_addr != LFS_ADDR_STATUS // [RULE18]
      |=> resp_frame[8] == 1'h0)
    else $error("reserved bit read nonzero");

  c_status_read: cover property (status_rd ##1 resp_valid);
  c_peak_write: cover property (ch1_dac_load);
  c_parity_fault: cover property (cmd_valid && cmd_parity_err ##1 resp_frame[15]);
  c_therm_warn: cover property ($rose(flags[LFS_BIT_THERM]));

endmodule

/* File: lfs_pkg.sv */
package lfs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [4:0] LFS_ADDR_STATUS = 5'h01;
  localparam logic [4:0] LFS_ADDR_LIMIT = 5'h02;
  localparam logic [4:0] LFS_ADDR_PEAK = 5'h03;
  localparam logic [7:0] LFS_LIMIT_RST = 8'h80;
  localparam logic [7:0] LFS_PEAK_RST = 8'h80;

  // ****************************************
  // status bit positions
  // ****************************************
  localparam int LFS_BIT_LINK = 0;
  localparam int LFS_BIT_THERM = 1;
  localparam int LFS_BIT_UV1 = 2;
  localparam int LFS_BIT_UV2 = 3;
  localparam int LFS_BIT_PC = 4;
  localparam int LFS_NFLAGS = 5;
  localparam logic [4:0] LFS_FLAGS_RST = 5'h10;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int LFS_FRAME_W = 16;
  localparam int LFS_DATA_W = 9;
  localparam logic [1:0] LFS_RSVD_ONES = 2'h3;
  localparam logic [15:0] LFS_ERR_FRAME = 16'h8000;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {
    LFS_PH_POR = 2'h0,
    LFS_PH_RUN = 2'h1
  } lfs_phase_t;

  typedef struct packed {
    lfs_phase_t phase;
    logic [7:0] limit;
    logic [7:0] peak;
    logic dac_load;
    logic [1:0] hs_off;
    logic over_temp;
    logic resp_valid;
    logic [15:0] resp;
  } lfs_state_t;

  typedef struct packed {
    logic flag;
  } lfs_cell_t;

endpackage

/* File: lfs_flag_cell.sv */
module lfs_flag_cell
  import lfs_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic cond_now,
  input wire logic clr_req,
  output logic flag
);

  lfs_cell_t s_r;
  lfs_cell_t s_nxt;

  // ****************************************
  // sticky flag, set wins over clear
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    if (set_evt || cond_now) begin
      s_nxt.flag = 1'h1;
    end else if (clr_req) begin
      s_nxt.flag = 1'h0;
    end
  end

  // register the state
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r.flag <= RST_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag = s_r.flag;

endmodule

/* File: lfs_host_model.sv */
module lfs_host_model
  import lfs_pkg::*;
(
  input wire logic mclk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [4:0] cmd_addr,
  output logic [lfs_pkg::LFS_DATA_W-1:0] cmd_data,
  output logic cmd_parity_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle after time zero
  initial begin
    cmd_valid = 0;
    cmd_write = 0;
    cmd_addr = 5'h00;
    cmd_data = 9'h000;
    cmd_parity_err = 0;
  end
  // one decoded frame for one cycle, then valid and parity drop low, write, address and data show the inverse
  task automatic send(input logic w, input logic [4:0] a, input logic [8:0] d, input logic p);
    @(posedge mclk);
    #1;
    {cmd_valid, cmd_write, cmd_addr, cmd_data, cmd_parity_err} = {1'h1, w, a, d, p};
    @(posedge mclk);
    #1;
    {cmd_valid, cmd_write, cmd_addr, cmd_data, cmd_parity_err} = {1'h0, ~w, ~a, ~d, 1'h0};
  endtask
endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import lfs_pkg::*;
  logic mclk, rst, frame_count_err, ch1_boot_uv, ch2_boot_uv, resp_valid, ch1_dac_load;
  logic ch1_hs_off, ch2_hs_off, cmd_valid, cmd_write, cmd_parity_err;
  logic [7:0] temp_adc_sample, temp_limit_code, ch1_peak_current_code, exp_peak;
  logic [4:0] cmd_addr, status_flags, a, m;
  logic [8:0] cmd_data, d;
  logic [15:0] resp_frame;
  int fail_count = 0;
  int compares = 0;
  lfs_host_model host (.mclk, .cmd_valid, .cmd_write, .cmd_addr, .cmd_data, .cmd_parity_err);
  lfs_regs DUT (.mclk, .rst, .cmd_valid, .cmd_write, .cmd_addr, .cmd_data, .cmd_parity_err,
    .frame_count_err, .ch1_boot_uv, .ch2_boot_uv, .temp_adc_sample, .resp_valid, .resp_frame,
    .status_flags, .temp_limit_code, .ch1_peak_current_code, .ch1_dac_load, .ch1_hs_off,
    .ch2_hs_off);
  // clock at 100 ns
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // expected frames
  function automatic logic [15:0] rf(input logic s, input logic [4:0] f, input logic [8:0] x);
    return {s, LFS_RSVD_ONES, f[4:1], x};
  endfunction
  function automatic logic [15:0] wf(input logic s, input logic [4:0] ad, input logic [8:0] x);
    return {s, 1'h1, ad, x};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one command, answer pulse and frame one edge later
  task automatic xfer(input logic w, input logic [4:0] ad, input logic [8:0] x, input logic p,
    input logic [15:0] e);
    host.send(w, ad, x, p);
    chk(16'(resp_valid), 16'h0001);
    chk(resp_frame, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (compares > 0 && fail_count == 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #3000000;
    fail_count++;
    final_report;
  end
  // main sequence
  initial begin
    void'($urandom(43946));
    {rst, frame_count_err, ch1_boot_uv, ch2_boot_uv, temp_adc_sample} = {4'h8, 8'h00};
    tick(2);
    rst = 0;
    chk(16'(status_flags), 16'(LFS_FLAGS_RST));
    chk(16'(temp_limit_code), 16'h0080);
    chk(16'(ch1_peak_current_code), 16'h0080);
    // first command after reset is a write: answered with the power-on frame, still stored
    xfer(1, LFS_ADDR_PEAK, 9'h055, 0, LFS_ERR_FRAME);
    exp_peak = 8'h55;
    chk(16'(ch1_peak_current_code), 16'(exp_peak));
    xfer(0, LFS_ADDR_STATUS, 9'h000, 0, rf(0, 5'h10, 9'h010));
    chk(16'(status_flags), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      a = ($urandom % 2) ? LFS_ADDR_LIMIT : LFS_ADDR_PEAK;
      d = 9'($urandom);
      xfer(1, a, d, 0, wf(0, a, d));
      if (a == LFS_ADDR_PEAK) begin
        exp_peak = d[7:0];
        chk(16'(ch1_dac_load), 16'h0001);
        chk(16'(ch1_peak_current_code), 16'(exp_peak));
      end
      xfer(0, a, 9'h000, 0, rf(0, 5'h00, {1'h0, d[7:0]}));
    end
    xfer(0, 5'h1F, 9'h000, 0, rf(0, 5'h00, 9'h000));
    xfer(1, LFS_ADDR_LIMIT, 9'h0A1, 0, wf(0, LFS_ADDR_LIMIT, 9'h0A1));
    temp_adc_sample = 8'hA1;
    tick(3);
    chk(16'(status_flags), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      m = 5'h02 << i;
      {ch2_boot_uv, ch1_boot_uv} = 2'(m >> 2);
      temp_adc_sample = (i == 0) ? 8'hA2 : 8'h00;
      tick(1);
      chk(16'({ch2_hs_off, ch1_hs_off}), 16'(m >> 2));
      tick(1);
      chk(16'(status_flags), 16'(m));
      xfer(0, LFS_ADDR_STATUS, 9'h000, 0, rf(0, m, 9'(m)));
      chk(16'(status_flags), 16'(m));
      {ch2_boot_uv, ch1_boot_uv, temp_adc_sample} = 10'h000;
      tick(2);
      xfer(0, LFS_ADDR_STATUS, 9'h000, 0, rf(0, m, 9'(m)));
      chk(16'(status_flags), 16'h0000);
    end
    xfer(0, LFS_ADDR_LIMIT, 9'h004, 0, rf(1, 5'h01, 9'h0A1));
    xfer(1, LFS_ADDR_PEAK, 9'h011, 1, LFS_ERR_FRAME);
    chk(16'(ch1_peak_current_code), 16'(exp_peak));
    xfer(1, LFS_ADDR_PEAK, 9'h022, 0, wf(1, LFS_ADDR_PEAK, 9'h022));
    xfer(0, LFS_ADDR_STATUS, 9'h000, 0, rf(1, 5'h01, 9'h001));
    chk(16'(status_flags), 16'h0000);
    frame_count_err = 1;
    tick(1);
    frame_count_err = 0;
    tick(1);
    chk(16'(status_flags), 16'h0001);
    xfer(0, LFS_ADDR_STATUS, 9'h000, 0, rf(1, 5'h01, 9'h001));
    xfer(0, LFS_ADDR_STATUS, 9'h000, 1, rf(1, 5'h00, 9'h000));
    chk(16'(status_flags), 16'h0001);
    // second power-on reset in mid-run
    rst = 1;
    tick(2);
    rst = 0;
    chk(16'(status_flags), 16'(LFS_FLAGS_RST));
    chk(16'(temp_limit_code), 16'(LFS_LIMIT_RST));
    xfer(1, LFS_ADDR_LIMIT, 9'h033, 0, LFS_ERR_FRAME);
    chk(16'(temp_limit_code), 16'h0033);
    final_report;
  end
endmodule
